// ### src/smo_blink_gen.sv
// Blink generator for the reset-required indication.
// Assumes a synchronous enable and an already synchronised active-low reset.
module smo_blink_gen #(
   parameter int unsigned HALF_CYCLES = smo_pkg::BLINK_HALF_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rstSync_b,
   smo_blink_if.gen bl
);
   logic [smo_pkg::TIMER_W-1:0] cnt_ff;
   logic [smo_pkg::TIMER_W-1:0] nxt_cnt;
   logic wave_ff;
   logic nxt_wave;
   localparam logic [smo_pkg::TIMER_W-1:0] LIMIT = smo_pkg::TIMER_W'(HALF_CYCLES - 1);

   // The wave is held low while idle so a lamp stays dark with nothing pending.
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_wave = wave_ff;
      if (!bl.enable) begin
         nxt_cnt = '0;
         nxt_wave = 1'b0;
      end else if (cnt_ff >= LIMIT) begin
         nxt_cnt = '0;
         nxt_wave = !wave_ff;
      end else begin
         nxt_cnt = cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         cnt_ff <= '0;
         wave_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         wave_ff <= nxt_wave;
      end
   end

   assign bl.wave = wave_ff;

   a_blink_idle_low: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
      !bl.enable |=> !wave_ff) else $error("Blink wave not low while idle.");
   a_blink_half_period: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
      (bl.enable && cnt_ff >= LIMIT) |=> (wave_ff != $past(wave_ff)))
      else $error("Blink wave did not toggle at half period.");
endmodule // smo_blink_gen

// ### src/smo_blink_if.sv
// Carrier between the monitor and its reset-required blink generator.
// Assumes both ends run on the same system clock.
interface smo_blink_if;
   logic enable;
   logic wave;
   modport gen (input enable, output wave);
   modport user (output enable, input wave);
endinterface

// ### src/smo_pkg.sv
// Shared constants and types of the safety output monitor.
// Assumes a single 200 MHz system clock for all of the block.
package smo_pkg;
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
   // Contactor response window, in milliseconds.
   localparam int unsigned RESP_TIME_MS = 300;
   localparam int unsigned RESP_CYCLES = RESP_TIME_MS * CLK_PER_MS;
   // Reset-required blink rate, in hertz; one half period is high, one low.
   localparam int unsigned BLINK_HZ = 1;
   localparam int unsigned BLINK_HALF_CYCLES = CLK_HZ / (2 * BLINK_HZ);
   localparam int unsigned TIMER_W = 32;
   localparam int unsigned SYNC_W = 3;
   // Bit positions inside the synchronised pin vector.
   localparam int unsigned PIN_RESET_BTN = 0;
   localparam int unsigned PIN_FEEDBACK = 1;
   localparam int unsigned PIN_SENDER_TEST = 2;
   // Fault codes shown on the fault code output.
   localparam logic [7:0] FAULT_NONE = 8'h00;
   localparam logic [7:0] FAULT_FB_CFG = 8'h22;
   localparam logic [7:0] FAULT_FB_RESP = 8'h23;

   typedef enum logic [1:0] {
      DIAG_CONTAM = 2'h0,
      DIAG_OUTSTATE = 2'h1,
      DIAG_RESETREQ = 2'h2,
      DIAG_MUTING = 2'h3
   } smo_diag_src_t;
endpackage

// ### src/smo_safety_output_monitor.sv
// Output-side control of a light-beam safety receiver: redundant safety outputs,
// contactor feedback supervision, restart interlock, reset-required and diagnostic outputs.
// Assumes beam, fault, contamination, muting and configuration inputs come from logic on
// sys_clk; the reset button, feedback and sender test pins are asynchronous.

module smo_safety_output_monitor #(
   parameter int unsigned RESP_CYCLES = smo_pkg::RESP_CYCLES,
   parameter int unsigned BLINK_HALF_CYCLES = smo_pkg::BLINK_HALF_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic beamClear,
   input wire logic deviceFault,
   input wire logic contaminationAlarm,
   input wire logic mutingActive,
   input wire logic cfgValid,
   input wire logic cfgResetEn,
   input wire logic cfgFeedbackEn,
   input wire smo_pkg::smo_diag_src_t cfgDiagSrc,
   input wire logic cfgDiagActiveHigh,
   input wire logic resetButtonPin,
   input wire logic contactorFeedbackPin,
   input wire logic senderTestPin_b,
   output logic safetyOutputA,
   output logic safetyOutputB,
   output logic resetRequired,
   output logic diagOutput,
   output logic diagOutputOe,
   output logic feedbackFault,
   output logic [7:0] faultCode,
   output logic testRequest
);
   typedef enum {
      ST_OFF,
      ST_WAIT_RESET,
      ST_CHECK_ON,
      ST_ON,
      ST_LOCK
   } smo_state_t;

   localparam logic [smo_pkg::TIMER_W-1:0] RESP_LIMIT = smo_pkg::TIMER_W'(RESP_CYCLES - 1);

   logic [1:0] rstChain_ff;
   logic rstSync_b;
   logic [smo_pkg::SYNC_W-1:0] pinMeta_ff;
   logic [smo_pkg::SYNC_W-1:0] pinSync_ff;
   logic buttonLast_ff;
   logic nxt_buttonLast;
   logic resetPress;
   logic feedbackHigh;
   logic interlockEn;
   logic cfgFault;
   logic tripped;
   logic timerDone;

   smo_state_t state_ff;
   smo_state_t nxt_state;
   logic [smo_pkg::TIMER_W-1:0] timer_ff;
   logic [smo_pkg::TIMER_W-1:0] nxt_timer;
   logic safetyOutputA_ff;
   logic nxt_safetyOutputA;
   logic safetyOutputB_ff;
   logic nxt_safetyOutputB;
   logic feedbackFault_ff;
   logic nxt_feedbackFault;
   logic [7:0] faultCode_ff;
   logic [7:0] nxt_faultCode;

   logic resetRequired_ff;
   logic nxt_resetRequired;
   logic diagOutput_ff;
   logic nxt_diagOutput;
   logic diagOutputOe_ff;
   logic nxt_diagOutputOe;
   logic testRequest_ff;
   logic nxt_testRequest;

   smo_blink_if blink ();

   // Reset is released through two flops; assertion stays asynchronous.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rstChain_ff <= 2'h0;
      end else begin
         rstChain_ff <= {rstChain_ff[0], 1'b1};
      end
   end
   assign rstSync_b = rstChain_ff[1];

   // Two-flop synchronisers; only the second stage is read by the logic.
   for (genvar i = 0; i < smo_pkg::SYNC_W; i++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rstSync_b) begin
         if (!rstSync_b) begin
            // The sender test pin idles high; starting there avoids a false test request.
            pinMeta_ff[i] <= 1'(i == smo_pkg::PIN_SENDER_TEST);
            pinSync_ff[i] <= 1'(i == smo_pkg::PIN_SENDER_TEST);
         end else begin
            pinMeta_ff[i] <= i == smo_pkg::PIN_SENDER_TEST ? senderTestPin_b :
               i == smo_pkg::PIN_FEEDBACK ? contactorFeedbackPin : resetButtonPin;
            pinSync_ff[i] <= pinMeta_ff[i];
         end
      end
   end

   // Diagnostic drive decision; returns the output enable, the level is always high.
   function automatic logic diagDrive(smo_pkg::smo_diag_src_t src, logic activeHigh,
                                      logic contam, logic outOn, logic wave, logic muting);
      logic cond;
      cond = 1'b0;
      case (src)
         smo_pkg::DIAG_CONTAM: cond = activeHigh ? contam : !contam;
         smo_pkg::DIAG_OUTSTATE: cond = activeHigh ? outOn : !outOn;
         smo_pkg::DIAG_RESETREQ: cond = wave;
         smo_pkg::DIAG_MUTING: cond = muting;
         default: cond = 1'b0;
      endcase
      return cond;
   endfunction

   assign feedbackHigh = pinSync_ff[smo_pkg::PIN_FEEDBACK];
   assign resetPress = pinSync_ff[smo_pkg::PIN_RESET_BTN] && !buttonLast_ff;
   // A replacement unit with no valid configuration runs without the interlock.
   assign interlockEn = cfgValid && cfgResetEn;
   // A high feedback level with monitoring off means contacts are wired unannounced.
   assign cfgFault = !cfgFeedbackEn && feedbackHigh;
   assign tripped = !beamClear || deviceFault || cfgFault;
   assign timerDone = timer_ff >= RESP_LIMIT;

   // Output state machine with contactor supervision.
   always_comb begin
      nxt_state = state_ff;
      nxt_buttonLast = pinSync_ff[smo_pkg::PIN_RESET_BTN];
      nxt_feedbackFault = feedbackFault_ff;
      case (state_ff)
         ST_OFF: begin
            if (cfgFeedbackEn && !feedbackHigh && timerDone) begin
               nxt_state = ST_LOCK;
               nxt_feedbackFault = 1'b1;
            end else if (!tripped && (!cfgFeedbackEn || feedbackHigh)) begin
               if (interlockEn) begin
                  nxt_state = ST_WAIT_RESET;
               end else begin
                  nxt_state = cfgFeedbackEn ? ST_CHECK_ON : ST_ON;
               end
            end
         end
         ST_WAIT_RESET: begin
            if (tripped) begin
               nxt_state = ST_OFF;
            end else if (resetPress) begin
               nxt_state = cfgFeedbackEn ? ST_CHECK_ON : ST_ON;
            end
         end
         ST_CHECK_ON: begin
            if (tripped) begin
               nxt_state = ST_OFF;
            end else if (!feedbackHigh) begin
               nxt_state = ST_ON;
               nxt_feedbackFault = 1'b0;
            end else if (timerDone) begin
               nxt_state = ST_OFF;
               nxt_feedbackFault = 1'b1;
            end
         end
         ST_ON: begin
            if (tripped) begin
               nxt_state = ST_OFF;
            end
         end
         ST_LOCK: begin
            // Leaving needs released contacts and a deliberate operator press.
            if (feedbackHigh && resetPress && !tripped) begin
               nxt_state = ST_OFF;
            end
         end
         default: nxt_state = ST_OFF;
      endcase
      nxt_timer = nxt_state != state_ff ? '0 : (timerDone ? timer_ff : timer_ff + 1'b1);
      nxt_safetyOutputA = nxt_state == ST_ON || nxt_state == ST_CHECK_ON;
      nxt_safetyOutputB = nxt_state == ST_ON || nxt_state == ST_CHECK_ON;
      if (cfgFault) begin
         nxt_faultCode = smo_pkg::FAULT_FB_CFG;
      end else if (nxt_feedbackFault) begin
         nxt_faultCode = smo_pkg::FAULT_FB_RESP;
      end else begin
         nxt_faultCode = smo_pkg::FAULT_NONE;
      end
   end

   always_ff @(posedge sys_clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         state_ff <= ST_OFF;
         timer_ff <= '0;
         buttonLast_ff <= 1'b0;
         safetyOutputA_ff <= 1'b0;
         safetyOutputB_ff <= 1'b0;
         feedbackFault_ff <= 1'b0;
         faultCode_ff <= smo_pkg::FAULT_NONE;
      end else begin
         state_ff <= nxt_state;
         timer_ff <= nxt_timer;
         buttonLast_ff <= nxt_buttonLast;
         safetyOutputA_ff <= nxt_safetyOutputA;
         safetyOutputB_ff <= nxt_safetyOutputB;
         feedbackFault_ff <= nxt_feedbackFault;
         faultCode_ff <= nxt_faultCode;
      end
   end

   assign blink.enable = state_ff == ST_WAIT_RESET;

   smo_blink_gen #(
      .HALF_CYCLES(BLINK_HALF_CYCLES)
   ) u_blink (
      .sys_clk(sys_clk),
      .rstSync_b(rstSync_b),
      .bl(blink.gen)
   );

   // Indicator, diagnostic and sender test outputs.
   always_comb begin
      nxt_resetRequired = blink.wave;
      nxt_diagOutput = 1'b1;
      nxt_diagOutputOe = diagDrive(cfgDiagSrc, cfgDiagActiveHigh, contaminationAlarm,
                                   safetyOutputA_ff, blink.wave, mutingActive);
      nxt_testRequest = !pinSync_ff[smo_pkg::PIN_SENDER_TEST];
   end

   always_ff @(posedge sys_clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         resetRequired_ff <= 1'b0;
         diagOutput_ff <= 1'b0;
         diagOutputOe_ff <= 1'b0;
         testRequest_ff <= 1'b0;
      end else begin
         resetRequired_ff <= nxt_resetRequired;
         diagOutput_ff <= nxt_diagOutput;
         diagOutputOe_ff <= nxt_diagOutputOe;
         testRequest_ff <= nxt_testRequest;
      end
   end

   assign safetyOutputA = safetyOutputA_ff;
   assign safetyOutputB = safetyOutputB_ff;
   assign resetRequired = resetRequired_ff;
   assign diagOutput = diagOutput_ff;
   assign diagOutputOe = diagOutputOe_ff;
   assign feedbackFault = feedbackFault_ff;
   assign faultCode = faultCode_ff;
   assign testRequest = testRequest_ff;

   a_resp_timeout_off: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
      (state_ff == ST_CHECK_ON && timerDone && feedbackHigh && !tripped)
      |=> !safetyOutputA_ff && !safetyOutputB_ff && feedbackFault_ff)
      else $error("Outputs on after timeout.");
   a_release_lock: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
      (state_ff == ST_OFF && cfgFeedbackEn && !feedbackHigh && timerDone)
      |=> state_ff == ST_LOCK ##1 !safetyOutputA_ff) else $error("No lock on stuck feedback.");
   a_cfg_fault_code: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
      (!cfgFeedbackEn && feedbackHigh) |=> faultCode_ff == smo_pkg::FAULT_FB_CFG)
      else $error("Missing feedback configuration fault code.");
   a_interlock_hold: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
      (state_ff == ST_WAIT_RESET && !resetPress) |=> !safetyOutputA_ff)
      else $error("Outputs on without reset press.");
   a_interlock_cfg: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
      (state_ff == ST_OFF && !tripped && !cfgFeedbackEn && !interlockEn) |=> safetyOutputA_ff)
      else $error("Unconfigured unit did not run without interlock.");
   a_beam_cut_off: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
      tripped |=> !safetyOutputA_ff && !safetyOutputB_ff)
      else $error("Outputs on while interrupted or faulted.");
   a_outputs_match: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
      safetyOutputA_ff == safetyOutputB_ff) else $error("Safety outputs disagree.");
   a_indicator_follow: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
      state_ff != ST_WAIT_RESET |=> ##1 !resetRequired_ff)
      else $error("Indicator active with no reset pending.");
   a_diag_high_act: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
      (cfgDiagSrc == smo_pkg::DIAG_CONTAM && cfgDiagActiveHigh)
      |=> diagOutputOe_ff == $past(contaminationAlarm)) else $error("Active-high diag wrong.");
   a_diag_low_act: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
      (cfgDiagSrc == smo_pkg::DIAG_OUTSTATE && !cfgDiagActiveHigh)
      |=> diagOutputOe_ff != $past(safetyOutputA_ff)) else $error("Active-low diag wrong.");
   a_diag_reset_req: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
      cfgDiagSrc == smo_pkg::DIAG_RESETREQ |=> diagOutputOe_ff == resetRequired_ff)
      else $error("Diag does not follow reset-required blink.");
   a_diag_muting: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
      cfgDiagSrc == smo_pkg::DIAG_MUTING |=> diagOutputOe_ff == $past(mutingActive))
      else $error("Muting diag depends on polarity.");
   a_test_request: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
      !pinSync_ff[smo_pkg::PIN_SENDER_TEST] |=> testRequest_ff)
      else $error("Low test input not taken as test request.");
endmodule // smo_safety_output_monitor

// ### tb/smo_machine_model.sv
// Machine side model: two contactors with guided N/C feedback contacts in series.
// Assumes the safety outputs come from the monitor on sys_clk.
module smo_machine_model (
   input wire logic sys_clk,
   input wire logic outA,
   input wire logic outB,
   input wire logic [1:0] mode,
   output logic feedbackPin
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] releasedPipe;

   // Contacts need a few cycles to drop out, so feedback lags the outputs.
   always @(posedge sys_clk) begin
      releasedPipe <= {releasedPipe[1:0], !(outA | outB)};
   end

   // Mode 0 is an unwired or welded contact, 2 a contactor that never pulls in.
   always_comb begin
      case (mode)
         2'h0: feedbackPin = 1'b0;
         2'h1: feedbackPin = releasedPipe[2];
         default: feedbackPin = 1'b1;
      endcase
   end
endmodule // smo_machine_model

// ### tb/smo_safety_output_monitor_tb.sv
// Self-checking bench of the safety output monitor with a machine side model.
// Assumes short response and blink counts set through the top module parameters.
`define CMP(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module smo_safety_output_monitor_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned RESP_N = 20;
   localparam int unsigned BLK_N = 4;
   typedef struct {string nm; int sel; logic [7:0] exp;} smo_note_t;
   smo_note_t notes[$];
   smo_note_t cur;
   logic sys_clk, rst_b, beamClear, deviceFault, contaminationAlarm, mutingActive;
   logic cfgValid, cfgResetEn, cfgFeedbackEn, cfgDiagActiveHigh;
   logic resetButtonPin, contactorFeedbackPin, senderTestPin_b;
   smo_pkg::smo_diag_src_t cfgDiagSrc;
   logic safetyOutputA, safetyOutputB, resetRequired, diagOutput, diagOutputOe;
   logic feedbackFault, testRequest, expOe;
   logic [7:0] faultCode;
   logic [1:0] fbMode;
   logic [31:0] r;
   int failures, checked, riseCnt, highCnt, seed;

   smo_safety_output_monitor #(.RESP_CYCLES(RESP_N), .BLINK_HALF_CYCLES(BLK_N)) dut_u (
      .sys_clk(sys_clk), .rst_b(rst_b), .beamClear(beamClear), .deviceFault(deviceFault),
      .contaminationAlarm(contaminationAlarm), .mutingActive(mutingActive),
      .cfgValid(cfgValid), .cfgResetEn(cfgResetEn), .cfgFeedbackEn(cfgFeedbackEn),
      .cfgDiagSrc(cfgDiagSrc), .cfgDiagActiveHigh(cfgDiagActiveHigh),
      .resetButtonPin(resetButtonPin), .contactorFeedbackPin(contactorFeedbackPin),
      .senderTestPin_b(senderTestPin_b), .safetyOutputA(safetyOutputA),
      .safetyOutputB(safetyOutputB), .resetRequired(resetRequired), .diagOutput(diagOutput),
      .diagOutputOe(diagOutputOe), .feedbackFault(feedbackFault), .faultCode(faultCode),
      .testRequest(testRequest));

   smo_machine_model model_u (.sys_clk(sys_clk), .outA(safetyOutputA),
      .outB(safetyOutputB), .mode(fbMode), .feedbackPin(contactorFeedbackPin));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   function automatic logic [7:0] obsOf(input int sel);
      case (sel)
         0: return {7'h00, safetyOutputA};
         1: return {7'h00, safetyOutputB};
         2: return {7'h00, diagOutputOe};
         3: return {7'h00, feedbackFault};
         4: return faultCode;
         5: return {7'h00, testRequest};
         6: return riseCnt[7:0];
         7: return highCnt[7:0];
         8: return {7'h00, diagOutput};
         default: return {7'h00, resetRequired};
      endcase
   endfunction

   // Outputs settle after the rising edge, so notes are judged on the falling one.
   always @(negedge sys_clk) begin
      while (notes.size() > 0) begin
         cur = notes.pop_front();
         `CMP(cur.nm, cur.exp, obsOf(cur.sel))
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic note(input string nm, input int sel, input logic [7:0] exp);
      notes.push_back('{nm, sel, exp});
   endtask

   task automatic doReset();
      // Let pending notes be judged before reset clears the outputs.
      cyc(1);
      rst_b = 1'b0;
      {beamClear, deviceFault, contaminationAlarm, mutingActive} = 4'h0;
      {cfgValid, cfgResetEn, cfgFeedbackEn, cfgDiagActiveHigh, resetButtonPin} = 5'h00;
      senderTestPin_b = 1'b1;
      fbMode = 2'h0;
      cfgDiagSrc = smo_pkg::DIAG_CONTAM;
      cyc(10);
      rst_b = 1'b1;
      cyc(4);
   endtask

   task automatic waitOn();
      int k;
      k = 0;
      while (safetyOutputA !== 1'b1 && k < 60) begin
         cyc(1);
         k++;
      end
   endtask

   // Counts rises over 32 cycles; a whole number of blink periods fits in that span.
   task automatic measure(input bit useDiag);
      logic prev, now;
      riseCnt = 0;
      highCnt = 0;
      prev = useDiag ? diagOutputOe : resetRequired;
      repeat (32) begin
         cyc(1);
         now = useDiag ? diagOutputOe : resetRequired;
         if (now === 1'b1) highCnt++;
         if (now === 1'b1 && prev === 1'b0) riseCnt++;
         prev = now;
      end
   endtask

   task automatic end_sim();
      if (failures == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      #50000;
      failures++;
      end_sim();
   end

   initial begin
      seed = 32'h2307;
      failures = 0;
      checked = 0;
      doReset();
      cfgResetEn = 1'b1;
      beamClear = 1'b1;
      cyc(4);
      note("outA unconfigured", 0, 8'h01);
      note("outB clear", 1, 8'h01);
      deviceFault = 1'b1;
      cyc(3);
      note("outA fault", 0, 8'h00);
      deviceFault = 1'b0;
      beamClear = 1'b0;
      cyc(3);
      note("outB broken", 1, 8'h00);
      doReset();
      {cfgValid, cfgResetEn, beamClear} = 3'h7;
      cfgDiagSrc = smo_pkg::DIAG_RESETREQ;
      cyc(6);
      note("outA interlocked", 0, 8'h00);
      measure(1'b0);
      note("blink rises", 6, 8'h04);
      note("blink high", 7, 8'(4 * BLK_N));
      cyc(1);
      measure(1'b1);
      note("diag blink rises", 6, 8'h04);
      cyc(1);
      resetButtonPin = 1'b1;
      cyc(4);
      resetButtonPin = 1'b0;
      cyc(6);
      note("outA after press", 0, 8'h01);
      note("blink idle", 9, 8'h00);
      doReset();
      {cfgFeedbackEn, beamClear} = 2'h3;
      fbMode = 2'h1;
      waitOn();
      cyc(RESP_N - 5);
      note("outA confirmed", 0, 8'h01);
      note("code healthy", 4, smo_pkg::FAULT_NONE);
      beamClear = 1'b0;
      cyc(10);
      note("fault after release", 3, 8'h00);
      doReset();
      {cfgFeedbackEn, beamClear} = 2'h3;
      fbMode = 2'h2;
      waitOn();
      cyc(RESP_N / 2);
      note("outA checking", 0, 8'h01);
      cyc(RESP_N);
      note("response fault", 3, 8'h01);
      note("response code", 4, smo_pkg::FAULT_FB_RESP);
      doReset();
      {cfgFeedbackEn, beamClear} = 2'h3;
      cyc(RESP_N + 10);
      note("outA welded", 0, 8'h00);
      note("welded fault", 3, 8'h01);
      // Contacts repaired: a press with released contacts leaves the lock.
      fbMode = 2'h1;
      resetButtonPin = 1'b1;
      cyc(4);
      resetButtonPin = 1'b0;
      cyc(8);
      note("outA unlocked", 0, 8'h01);
      note("fault cleared", 3, 8'h00);
      doReset();
      fbMode = 2'h1;
      beamClear = 1'b1;
      cyc(10);
      note("cfg code", 4, smo_pkg::FAULT_FB_CFG);
      note("outA cfg fault", 0, 8'h00);
      doReset();
      for (int i = 0; i < 12; i++) begin
         r = $random(seed);
         {beamClear, contaminationAlarm, mutingActive, cfgDiagActiveHigh} = r[3:0];
         senderTestPin_b = r[4];
         cfgDiagSrc = (i % 3 == 2) ? smo_pkg::DIAG_MUTING : smo_pkg::smo_diag_src_t'(i % 3);
         cyc(6);
         case (i % 3)
            0: expOe = cfgDiagActiveHigh ? contaminationAlarm : !contaminationAlarm;
            1: expOe = cfgDiagActiveHigh ? beamClear : !beamClear;
            default: expOe = mutingActive;
         endcase
         note("outA random", 0, {7'h00, beamClear});
         note("diag enable", 2, {7'h00, expOe});
         if (expOe) note("diag level", 8, 8'h01);
         note("test request", 5, {7'h00, !senderTestPin_b});
      end
      cyc(2);
      end_sim();
   end
endmodule // smo_safety_output_monitor_tb
